// ===== hw/adc_out_pkg.sv
// Purpose: constants for the converter output test and configuration bank
// Assumes: one channel per instance, 16-bit offset-binary samples from the core
// Notes: register offsets are the bank's byte addresses on the serial port
//
// Contract
// - four-bit test field; zero passes normal data, nonzero codes substitute test data
// - test field resets to off, so normal data flows after reset
// - code 0001 midscale, 0010 positive full scale, 0011 negative full scale
// - code 0100 alternates complementary checkerboard words each sample
// - code 0101 emits 23-stage sequence, code 0110 emits 9-stage sequence
// - code 0111 toggles whole word between all ones and all zeros
// - 1001 bit toggle, 1011 single bit high, 1100 mixed frequency; 1010 undefined
// - format register selects output level and offset binary, twos or gray format
// - phase field delays divider output by 0 to 6 input clock cycles
// - phase picks output clock phase; internal sample latching timing never moves
package adc_out_pkg;
   localparam int DATA_W = 16;

   // register offsets
   localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0d;
   localparam logic [7:0] ADDR_SELF_TEST    = 8'h0e;
   localparam logic [7:0] ADDR_OFFSET_TRIM  = 8'h10;
   localparam logic [7:0] ADDR_OUT_FORMAT   = 8'h14;
   localparam logic [7:0] ADDR_DRIVE        = 8'h15;
   localparam logic [7:0] ADDR_CLOCK_PHASE  = 8'h16;

   // reset values
   localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
   localparam logic [7:0] RST_SELF_TEST    = 8'h00;
   localparam logic [7:0] RST_OFFSET_TRIM  = 8'h00;
   localparam logic [7:0] RST_OUT_FORMAT   = 8'h00;
   localparam logic [7:0] RST_DRIVE        = 8'h22;
   localparam logic [7:0] RST_CLOCK_PHASE  = 8'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // field positions
   localparam int TP_CODE_LSB   = 0;
   localparam int TP_RST_SHORT  = 4;
   localparam int TP_RST_LONG   = 5;
   localparam int TP_USER_LSB   = 6;
   localparam int ST_ENABLE     = 0;
   localparam int ST_INIT       = 2;
   localparam int FMT_LSB       = 0;
   localparam int FMT_DISABLE   = 4;
   localparam int FMT_MUX       = 5;
   localparam int FMT_LEVEL_LSB = 6;
   localparam int PH_LSB        = 0;
   localparam int PH_INVERT     = 7;
   localparam logic [2:0] PHASE_MAX = 3'h6;

   // output test codes
   localparam logic [3:0] TC_OFF      = 4'h0;
   localparam logic [3:0] TC_MID      = 4'h1;
   localparam logic [3:0] TC_POS_FS   = 4'h2;
   localparam logic [3:0] TC_NEG_FS   = 4'h3;
   localparam logic [3:0] TC_CHECKER  = 4'h4;
   localparam logic [3:0] TC_LONG_PN  = 4'h5;
   localparam logic [3:0] TC_SHORT_PN = 4'h6;
   localparam logic [3:0] TC_WORD_TGL = 4'h7;
   localparam logic [3:0] TC_USER     = 4'h8;
   localparam logic [3:0] TC_BIT_TGL  = 4'h9;
   localparam logic [3:0] TC_ONE_HIGH = 4'hb;
   localparam logic [3:0] TC_MIXED    = 4'hc;

   // data formats and levels
   localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
   localparam logic [1:0] FMT_TWOS       = 2'h1;
   localparam logic [1:0] FMT_GRAY       = 2'h2;
   localparam logic [1:0] LEVEL_3V3      = 2'h0;
   localparam logic [1:0] LEVEL_1V8      = 2'h2;

   // fixed words, offset binary
   localparam logic [15:0] WORD_MID     = 16'h8000;
   localparam logic [15:0] WORD_POS_FS  = 16'hffff;
   localparam logic [15:0] WORD_NEG_FS  = 16'h0000;
   localparam logic [15:0] WORD_CHECK_A = 16'haaaa;
   localparam logic [15:0] WORD_CHECK_B = 16'h5555;
   localparam logic [15:0] WORD_ONES    = 16'hffff;
   localparam logic [15:0] WORD_ZEROS   = 16'h0000;
   localparam logic [15:0] WORD_BIT_TGL = 16'haaaa;
   localparam logic [15:0] WORD_WALK    = 16'h0001;
   localparam logic [15:0] WORD_MIXED   = 16'ha0f0;
   localparam logic [22:0] SEED_LONG    = 23'h7f_ffff;
   localparam logic [8:0]  SEED_SHORT   = 9'h1ff;
   localparam int LONG_TAP  = 17;
   localparam int SHORT_TAP = 4;

   typedef enum logic [1:0] {USER_SINGLE, USER_ALT, USER_SINGLE_ONCE, USER_ALT_ONCE} user_mode_e;

   // offset binary to the selected output format
   function automatic logic [15:0] fmt_conv(input logic [15:0] d, input logic [1:0] fmt);
      logic [15:0] r;
      r = d;
      if (fmt == FMT_TWOS)
      begin
         r = {~d[15], d[14:0]};
      end
      else if (fmt == FMT_GRAY)
      begin
         r = d ^ (d >> 1);
      end
      return r;
   endfunction

   // offset binary sample plus signed trim, clamped to the code range
   function automatic logic [15:0] trim_add(input logic [15:0] d, input logic [7:0] trim);
      logic signed [17:0] s;
      s = $signed({2'h0, d}) + $signed({{10{trim[7]}}, trim});
      if (s < 0)
      begin
         return WORD_NEG_FS;
      end
      if (s > $signed({2'h0, WORD_POS_FS}))
      begin
         return WORD_POS_FS;
      end
      return s[15:0];
   endfunction
endpackage

// ===== hw/out_cfg_if.sv
// Purpose: carrier between the register bank, pattern source and clock divider
// Assumes: single clock domain
// Notes: pattern and strobe are combinational from their producers
`timescale 1ns/1ps
`default_nettype none
interface out_cfg_if;
   logic        strobe;
   logic [3:0]  test_code;
   logic [1:0]  user_mode;
   logic        rst_long;
   logic        rst_short;
   logic [15:0] user_patt1;
   logic [15:0] user_patt2;
   logic [15:0] pattern;
   logic [2:0]  div_ratio;
   logic [2:0]  phase;
   logic        dco_inv;
   logic        output_data_clock;

   modport ctrl (output test_code, user_mode, rst_long, rst_short, user_patt1, user_patt2,
                 output div_ratio, phase, dco_inv, input strobe, pattern, output_data_clock);
   modport gen  (input strobe, test_code, user_mode, rst_long, rst_short, user_patt1,
                 input user_patt2, output pattern);
   modport divm (input div_ratio, phase, dco_inv, output strobe, output_data_clock);
endinterface
`default_nettype wire

// ===== hw/out_clock_div.sv
// Purpose: sample strobe and phase-shifted output data clock from the input clock
// Assumes: divide ratio is the value plus one, up to eight
// Notes: divide by one gives a steady output clock level in this one-clock design
`timescale 1ns/1ps
`default_nettype none
module out_clock_div
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // configuration and results
   out_cfg_if.divm   cfg
);
   logic [2:0] cnt_r;
   logic       dco_r;
   logic [3:0] div_n;
   logic [3:0] ph_eff;
   logic [3:0] ph_mod;
   logic [3:0] pc;

   always_comb
   begin
      div_n  = {1'b0, cfg.div_ratio} + 4'h1;
      ph_eff = {1'b0, (cfg.phase > PHASE_MAX) ? PHASE_MAX : cfg.phase};
      ph_mod = ph_eff % div_n;
      pc     = {1'b0, cnt_r} + div_n - ph_mod;
      if (pc >= div_n)
      begin
         pc = pc - div_n;
      end
   end

   // latching strobe ignores the phase field
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r <= 3'h0;
      end
      else if (cnt_r >= cfg.div_ratio)
      begin
         cnt_r <= 3'h0;
      end
      else
      begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dco_r <= 1'b0;
      end
      else
      begin
         dco_r <= (pc < ((div_n + 4'h1) >> 1)) ^ cfg.dco_inv;
      end
   end

   assign cfg.strobe = (cnt_r == 3'h0);
   assign cfg.output_data_clock    = dco_r;

   AST_PHASE_DELAY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (cnt_r == ph_mod[2:0]) && (div_n > 4'h1) |=> dco_r == !$past(cfg.dco_inv))
      else $error("output clock edge not at selected phase");

   AST_LATCH_FIXED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.strobe && (cfg.div_ratio != 3'h0) && $stable(cfg.div_ratio) |=> !cfg.strobe)
      else $error("sample strobe moved by phase setting");
endmodule
`default_nettype wire

// ===== hw/out_pattern_gen.sv
// Purpose: test word source for the output stage
// Assumes: advances once per sample strobe
// Notes: fixed levels are formed in the top so they follow the data format
`timescale 1ns/1ps
`default_nettype none
module out_pattern_gen
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // configuration and pattern
   out_cfg_if.gen    cfg
);
   logic [22:0] pn_long_r;
   logic [8:0]  pn_short_r;
   logic        tog_r;
   logic [15:0] walk_r;
   logic [15:0] mix_r;
   logic        user_idx_r;
   logic        user_done_r;
   logic        is_user;

   assign is_user = (cfg.test_code == TC_USER);

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pn_long_r  <= SEED_LONG;
         pn_short_r <= SEED_SHORT;
      end
      else
      begin
         if (cfg.rst_long)
            pn_long_r <= SEED_LONG;
         else if (cfg.strobe)
            pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[LONG_TAP]};
         if (cfg.rst_short)
            pn_short_r <= SEED_SHORT;
         else if (cfg.strobe)
            pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[SHORT_TAP]};
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tog_r  <= 1'b0;
         walk_r <= WORD_WALK;
         mix_r  <= WORD_MIXED;
      end
      else if (cfg.strobe)
      begin
         tog_r  <= ~tog_r;
         walk_r <= {walk_r[14:0], walk_r[15]};
         mix_r  <= {mix_r[14:0], mix_r[15]};
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         user_idx_r  <= 1'b0;
         user_done_r <= 1'b0;
      end
      else if (!is_user)
      begin
         user_idx_r  <= 1'b0;
         user_done_r <= 1'b0;
      end
      else if (cfg.strobe && !user_done_r)
      begin
         unique case (user_mode_e'(cfg.user_mode))
            USER_SINGLE:      user_idx_r <= 1'b0;
            USER_ALT:         user_idx_r <= ~user_idx_r;
            USER_SINGLE_ONCE: user_done_r <= 1'b1;
            USER_ALT_ONCE:
            begin
               user_idx_r  <= 1'b1;
               user_done_r <= user_idx_r;
            end
         endcase
      end
   end

   always_comb
   begin
      unique case (cfg.test_code)
         TC_CHECKER:  cfg.pattern = tog_r ? WORD_CHECK_B : WORD_CHECK_A;
         TC_LONG_PN:  cfg.pattern = pn_long_r[15:0];
         TC_SHORT_PN: cfg.pattern = {pn_short_r[6:0], pn_short_r};
         TC_WORD_TGL: cfg.pattern = tog_r ? WORD_ONES : WORD_ZEROS;
         TC_USER:     cfg.pattern = user_done_r ? WORD_ZEROS
                                    : (user_idx_r ? cfg.user_patt2 : cfg.user_patt1);
         TC_BIT_TGL:  cfg.pattern = WORD_BIT_TGL;
         TC_ONE_HIGH: cfg.pattern = walk_r;
         TC_MIXED:    cfg.pattern = mix_r;
         default:     cfg.pattern = WORD_ZEROS;
      endcase
   end

   AST_CHECK_ALT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.strobe && (cfg.test_code == TC_CHECKER) ##1 (cfg.test_code == TC_CHECKER)
      |-> cfg.pattern == ~$past(cfg.pattern))
      else $error("checkerboard did not alternate");

   AST_SHORT_PN_STEP: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.strobe && !cfg.rst_short
      |=> pn_short_r == {$past(pn_short_r[7:0]), $past(pn_short_r[8] ^ pn_short_r[SHORT_TAP])})
      else $error("short sequence step wrong");

   AST_WORD_TOGGLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.strobe && (cfg.test_code == TC_WORD_TGL) ##1 (cfg.test_code == TC_WORD_TGL)
      |-> (cfg.pattern == ~$past(cfg.pattern)) && ((cfg.pattern == WORD_ONES)
          || (cfg.pattern == WORD_ZEROS)))
      else $error("word toggle pattern wrong");

   AST_ONE_HIGH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.test_code == TC_ONE_HIGH |-> $onehot(cfg.pattern))
      else $error("single bit high pattern broken");

   AST_USER_ONCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      is_user && cfg.strobe && (cfg.user_mode == 2'(USER_SINGLE_ONCE)) ##1 is_user
      |-> user_done_r && (cfg.pattern == WORD_ZEROS))
      else $error("single once user pattern repeated");
endmodule
`default_nettype wire

// ===== hw/adc_output_test_config.sv
// Purpose: output stage configuration bank with test pattern substitution
// Assumes: register port is the decoded serial port, one access per cycle
// Notes: data leaves one cycle and, at phase 0, the output clock edge two cycles after the sample strobe
`timescale 1ns/1ps
`default_nettype none
module adc_output_test_config
   import adc_out_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // register port
   input  wire logic        reg_wr_en_in,
   input  wire logic        reg_rd_en_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   // converter core side
   input  wire logic [15:0] sample_in,
   input  wire logic [15:0] user_patt1_in,
   input  wire logic [15:0] user_patt2_in,
   input  wire logic [2:0]  div_ratio_in,
   // output pins and pad controls
   output logic      [15:0] data_out,
   output logic             output_data_clock_out,
   output logic             output_disable_bar_out,
   output logic             output_mux_en_out,
   output logic      [1:0]  output_level_out,
   output logic      [7:0]  output_drive_out,
   output logic             builtin_self_test_en_out,
   output logic             builtin_self_test_init_out
);
   logic [7:0]  test_pattern_control_r;
   logic [7:0]  self_test_control_r;
   logic [7:0]  offset_trim_r;
   logic [7:0]  output_format_control_r;
   logic [7:0]  output_drive_strength_r;
   logic [7:0]  output_clock_phase_r;
   logic [7:0]  rdata_r;
   logic [15:0] data_r;
   logic [15:0] data_nxt;
   logic        dco_r;
   logic        out_on_r;
   logic [3:0]  code;
   logic [1:0]  fmt;

   out_cfg_if cfg ();

   out_pattern_gen u_gen (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .cfg        (cfg.gen)
   );

   out_clock_div u_div (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .cfg        (cfg.divm)
   );

   // decoded read of the bank
   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      logic [7:0] r;
      r = READ_UNMAPPED;
      unique case (addr)
         ADDR_TEST_PATTERN: r = test_pattern_control_r;
         ADDR_SELF_TEST:    r = self_test_control_r;
         ADDR_OFFSET_TRIM:  r = offset_trim_r;
         ADDR_OUT_FORMAT:   r = output_format_control_r;
         ADDR_DRIVE:        r = output_drive_strength_r;
         ADDR_CLOCK_PHASE:  r = output_clock_phase_r;
         default:           r = READ_UNMAPPED;
      endcase
      return r;
   endfunction

   // register writes
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         test_pattern_control_r  <= RST_TEST_PATTERN;
         self_test_control_r     <= RST_SELF_TEST;
         offset_trim_r           <= RST_OFFSET_TRIM;
         output_format_control_r <= RST_OUT_FORMAT;
         out_on_r <= ~RST_OUT_FORMAT[FMT_DISABLE];
         output_drive_strength_r <= RST_DRIVE;
         output_clock_phase_r    <= RST_CLOCK_PHASE;
      end
      else if (reg_wr_en_in)
      begin
         unique case (reg_addr_in)
            ADDR_TEST_PATTERN: test_pattern_control_r  <= reg_wdata_in;
            ADDR_SELF_TEST:    self_test_control_r     <= reg_wdata_in;
            ADDR_OFFSET_TRIM:  offset_trim_r           <= reg_wdata_in;
            ADDR_OUT_FORMAT:
            begin
               output_format_control_r <= reg_wdata_in;
               out_on_r <= ~reg_wdata_in[FMT_DISABLE];
            end
            ADDR_DRIVE:        output_drive_strength_r <= reg_wdata_in;
            ADDR_CLOCK_PHASE:  output_clock_phase_r    <= reg_wdata_in;
            default:
            begin
            end
         endcase
      end
   end

   // register reads, answered one cycle after the read strobe
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rdata_r <= READ_UNMAPPED;
      end
      else if (reg_rd_en_in)
      begin
         rdata_r <= reg_read(reg_addr_in);
      end
   end

   // configuration toward pattern source and divider
   assign code               = test_pattern_control_r[TP_CODE_LSB +: 4];
   assign fmt                = output_format_control_r[FMT_LSB +: 2];
   assign cfg.test_code      = code;
   assign cfg.user_mode      = test_pattern_control_r[TP_USER_LSB +: 2];
   assign cfg.rst_long       = test_pattern_control_r[TP_RST_LONG];
   assign cfg.rst_short      = test_pattern_control_r[TP_RST_SHORT];
   assign cfg.user_patt1     = user_patt1_in;
   assign cfg.user_patt2     = user_patt2_in;
   assign cfg.div_ratio      = div_ratio_in;
   assign cfg.phase          = output_clock_phase_r[PH_LSB +: 3];
   assign cfg.dco_inv        = output_clock_phase_r[PH_INVERT];

   // output word selection
   always_comb
   begin
      unique case (code)
         TC_OFF:    data_nxt = fmt_conv(trim_add(sample_in, offset_trim_r), fmt);
         TC_MID:    data_nxt = fmt_conv(WORD_MID, fmt);
         TC_POS_FS: data_nxt = fmt_conv(WORD_POS_FS, fmt);
         TC_NEG_FS: data_nxt = fmt_conv(WORD_NEG_FS, fmt);
         default:   data_nxt = cfg.pattern;
      endcase
   end

   // output data latched on the internal sample strobe only
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         data_r <= WORD_ZEROS;
      end
      else if (cfg.strobe)
      begin
         data_r <= data_nxt;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         dco_r <= 1'b0;
      end
      else
      begin
         dco_r <= cfg.output_data_clock;
      end
   end

   assign reg_rdata_out              = rdata_r;
   assign data_out                   = data_r;
   assign output_data_clock_out      = dco_r;
   assign output_disable_bar_out     = out_on_r;
   assign output_mux_en_out          = output_format_control_r[FMT_MUX];
   assign output_level_out           = output_format_control_r[FMT_LEVEL_LSB +: 2];
   assign output_drive_out           = output_drive_strength_r;
   assign builtin_self_test_en_out   = self_test_control_r[ST_ENABLE];
   assign builtin_self_test_init_out = self_test_control_r[ST_INIT];

   sequence s_code_write(logic [3:0] c);
      reg_wr_en_in && (reg_addr_in == ADDR_TEST_PATTERN) && (reg_wdata_in[3:0] == c);
   endsequence

   sequence s_strobe_in(logic [3:0] c);
      cfg.strobe && (code == c);
   endsequence

   AST_NORMAL_PASS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_strobe_in(TC_OFF)
      |=> data_r == fmt_conv(trim_add($past(sample_in), $past(offset_trim_r)), $past(fmt)))
      else $error("normal data path wrong");

   AST_RESET_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (code == TC_OFF))
      else $error("test field not off after reset");

   AST_MIDSCALE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_code_write(TC_MID) ##1 s_strobe_in(TC_MID)
      |=> data_r == fmt_conv(WORD_MID, $past(fmt)))
      else $error("midscale word wrong");

   AST_FULL_SCALE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_strobe_in(TC_POS_FS) |=> data_r == fmt_conv(WORD_POS_FS, $past(fmt)))
      else $error("positive full scale word wrong");

   AST_TEST_SUBST: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cfg.strobe && (code >= TC_CHECKER) |=> data_r == $past(cfg.pattern))
      else $error("test data not substituted");

   AST_LEVEL_SEL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_wr_en_in && (reg_addr_in == ADDR_OUT_FORMAT)
      |=> (output_level_out == $past(reg_wdata_in[FMT_LEVEL_LSB +: 2]))
          && (fmt == $past(reg_wdata_in[FMT_LSB +: 2])))
      else $error("output level or format not taken");
endmodule
`default_nettype wire

// ===== verif/reg_host_model.sv
// Purpose: host side of the decoded register port
// Assumes: strobes change just after a rising edge and drop after the taking edge
// Notes: read data is taken just after the taking edge
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
(
   // clock
   input  wire logic       sys_clk_in,
   // register port
   input  wire logic [7:0] rdata_in,
   output logic            wr_en_out,
   output logic            rd_en_out,
   output logic      [7:0] addr_out,
   output logic      [7:0] wdata_out
);
   initial
   begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out  = 8'h00;
      wdata_out = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      wr_en_out <= 1'b1;
      addr_out  <= a;
      wdata_out <= d;
      @(posedge sys_clk_in);
      wr_en_out <= 1'b0;
      wdata_out <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      rd_en_out <= 1'b1;
      addr_out  <= a;
      @(posedge sys_clk_in);
      rd_en_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

// ===== verif/adc_output_test_config_tb.sv
// Purpose: self-checking bench for the output test and configuration bank
// Assumes: host model drives the register port, bench drives samples
// Notes: divide ratio stays 0 until the final phase test
`timescale 1ns/1ps
`default_nettype none
module adc_output_test_config_tb
   import adc_out_pkg::*;
;
   logic        clk;
   logic        rst_n;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic [15:0] smp;
   logic [15:0] p1;
   logic [15:0] p2;
   logic [2:0]  ratio;
   logic [15:0] dout;
   logic        output_data_clock;
   logic        out_on;
   logic        mux;
   logic [1:0]  level;
   logic [7:0]  drive;
   logic        st_en;
   logic        st_init;
   logic        track;
   int          cyc;
   int          n_mismatch;
   int          check_count;

   adc_output_test_config adc_output_test_config_i (.sys_clk_in(clk), .rst_n_in(rst_n),
      .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .sample_in(smp), .user_patt1_in(p1), .user_patt2_in(p2),
      .div_ratio_in(ratio), .data_out(dout), .output_data_clock_out(output_data_clock),
      .output_disable_bar_out(out_on), .output_mux_en_out(mux), .output_level_out(level),
      .output_drive_out(drive), .builtin_self_test_en_out(st_en),
      .builtin_self_test_init_out(st_init));
   reg_host_model reg_host_model_i (.sys_clk_in(clk), .rdata_in(rdata), .wr_en_out(wr_en),
      .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (track)
         smp <= smp + 16'h0001;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic set(input logic [7:0] a, input logic [7:0] d);
      reg_host_model_i.wr(a, d);
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic word(output logic [15:0] w);
      @(posedge clk);
      #1;
      w = dout;
   endtask

   task automatic t_reset;
      logic [7:0] a [7] = '{ADDR_TEST_PATTERN, ADDR_SELF_TEST, ADDR_OFFSET_TRIM,
                            ADDR_OUT_FORMAT, ADDR_DRIVE, ADDR_CLOCK_PHASE, 8'h20};
      logic [7:0] e [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00, 8'h00};
      logic [7:0] r;
      chk(16'(drive), 16'h0022);
      chk(16'(out_on), 16'h0001);
      for (int i = 0; i < 7; i++)
      begin
         reg_host_model_i.rd(a[i], r);
         chk(16'(r), 16'(e[i]));
      end
      $display("test reset done");
   endtask
   task automatic t_normal;
      smp <= 16'h1234;
      set(ADDR_OFFSET_TRIM, 8'h00);
      chk(dout, 16'h1234);
      set(ADDR_OFFSET_TRIM, 8'h05);
      chk(dout, 16'h1239);
      smp <= 16'h0002;
      set(ADDR_OFFSET_TRIM, 8'hfb);
      chk(dout, 16'h0000);
      smp <= 16'h1234;
      set(ADDR_OFFSET_TRIM, 8'h00);
      set(ADDR_OUT_FORMAT, 8'h02);
      chk(dout, 16'h1b2e);
      set(ADDR_OUT_FORMAT, 8'h01);
      chk(dout, 16'h9234);
      set(ADDR_OUT_FORMAT, 8'h00);
      $display("test normal done");
   endtask
   task automatic t_fixed;
      logic [3:0]  c [5] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha};
      logic [15:0] e [5] = '{16'h8000, 16'hffff, 16'h0000, 16'haaaa, 16'h0000};
      for (int i = 0; i < 5; i++)
      begin
         set(ADDR_TEST_PATTERN, {4'h0, c[i]});
         chk(dout, e[i]);
      end
      $display("test fixed done");
   endtask
   task automatic t_toggle;
      logic [15:0] w0;
      logic [15:0] w1;
      set(ADDR_TEST_PATTERN, 8'h04);
      word(w0);
      word(w1);
      chk(w0 ^ w1, 16'hffff);
      chk(w0 ^ {w0[14:0], w0[15]}, 16'hffff);
      set(ADDR_TEST_PATTERN, 8'h07);
      word(w0);
      word(w1);
      chk(w0 ^ w1, 16'hffff);
      chk(w0 ^ {w0[14:0], w0[15]}, 16'h0000);
      for (int i = 0; i < 2; i++)
      begin
         set(ADDR_TEST_PATTERN, i ? 8'h0c : 8'h0b);
         word(w0);
         word(w1);
         chk(w1, {w0[14:0], w0[15]});
         chk(16'($countones(w0)), i ? 16'h0006 : 16'h0001);
      end
      set(ADDR_TEST_PATTERN, 8'h16);
      word(w0);
      word(w1);
      chk(w0 & w1, 16'hffff);
      set(ADDR_TEST_PATTERN, 8'h06);
      word(w0);
      word(w1);
      chk(16'(w0 != w1), 16'h0001);
      set(ADDR_TEST_PATTERN, 8'h25);
      chk(dout, 16'hffff);
      $display("test toggle done");
   endtask
   task automatic t_user;
      logic [15:0] w0;
      logic [15:0] w1;
      p1 <= 16'h1357;
      p2 <= 16'h2468;
      set(ADDR_TEST_PATTERN, 8'h08);
      chk(dout, 16'h1357);
      set(ADDR_TEST_PATTERN, 8'h48);
      word(w0);
      word(w1);
      chk(w0 ^ w1, 16'h373f);
      set(ADDR_TEST_PATTERN, 8'h00);
      set(ADDR_TEST_PATTERN, 8'hc8);
      chk(dout, 16'h0000);
      set(ADDR_TEST_PATTERN, 8'h00);
      reg_host_model_i.wr(ADDR_TEST_PATTERN, 8'h88);
      word(w0);
      word(w1);
      chk(w0, 16'h1357);
      chk(w1, 16'h0000);
      set(ADDR_TEST_PATTERN, 8'h00);
      $display("test user done");
   endtask
   task automatic t_pads;
      logic [7:0] r;
      set(ADDR_OUT_FORMAT, 8'hb0);
      chk({12'h000, level, mux, out_on}, 16'h000a);
      reg_host_model_i.rd(ADDR_OUT_FORMAT, r);
      chk(16'(r), 16'h00b0);
      set(ADDR_SELF_TEST, 8'h05);
      chk({14'h0000, st_init, st_en}, 16'h0003);
      set(ADDR_DRIVE, 8'h5a);
      chk(16'(drive), 16'h005a);
      set(ADDR_OUT_FORMAT, 8'h00);
      $display("test pads done");
   endtask
   task automatic meas(output int r, output int d);
      logic        c0;
      logic [15:0] w0;
      repeat (12) @(posedge clk);
      #1;
      c0 = output_data_clock;
      w0 = dout;
      r = -1;
      d = -1;
      repeat (6)
      begin
         @(posedge clk);
         #1;
         if (output_data_clock === 1'b1 && c0 === 1'b0)
            r = cyc % 6;
         if (dout !== w0)
            d = cyc % 6;
         c0 = output_data_clock;
         w0 = dout;
      end
   endtask
   task automatic t_phase;
      int r0;
      int d0;
      int r;
      int d;
      ratio <= 3'h5;
      track <= 1'b1;
      set(ADDR_CLOCK_PHASE, 8'h00);
      meas(r0, d0);
      for (int p = 1; p < 9; p++)
      begin
         set(ADDR_CLOCK_PHASE, p == 8 ? 8'h80 : 8'(p));
         meas(r, d);
         chk(16'(d), 16'(d0));
         chk(16'(r), 16'((r0 + (p == 8 ? 3 : (p > 6 ? 6 : p))) % 6));
      end
      $display("test phase done");
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial
   begin
      rst_n = 1'b0;
      smp = 16'h0000;
      p1 = 16'h0000;
      p2 = 16'h0000;
      ratio = 3'h0;
      track = 1'b0;
      cyc = 0;
      n_mismatch = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_normal();
      t_fixed();
      t_toggle();
      t_user();
      t_pads();
      t_phase();
      close_out();
   end
endmodule
`default_nettype wire
